// ### hdl/uhb_defs.svh
// constants of the host port and the serial core
`ifndef UHB_DEFS_SVH
`define UHB_DEFS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define UHB_CLK_NS      10
`define UHB_RST_NS      40
`define UHB_RST_CYC     ((`UHB_RST_NS + `UHB_CLK_NS - 1) / `UHB_CLK_NS)

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define UHB_A_DATA      3'h0
`define UHB_A_DIVL      3'h1
`define UHB_A_DIVH      3'h2
`define UHB_A_FRAC      3'h3
`define UHB_A_TRIG      3'h4
`define UHB_A_FEATURE_CTRL_REG      3'h5
`define UHB_A_STAT      3'h6
`define UHB_A_CNT       3'h7

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define UHB_FEATURE_CTRL_REG_DUPLEX 3
`define UHB_FEATURE_CTRL_REG_FLOW   0
`define UHB_FRAC_PRESC  7
`define UHB_DIVL_RST    8'h01
`define UHB_DIVH_RST    8'h00
`define UHB_FRAC_RST    4'h0
`define UHB_TRIG_RST    8'h00
`define UHB_FEATURE_CTRL_REG_RST    8'h00
`define UHB_XOFF_RST    8'h13
`define UHB_XON_RST     8'h11
`define UHB_FIFO_DEPTH  64
`define UHB_ONE_DIV     20'h00010

`endif

// ### hdl/uhb_pkg.sv
// types of the host port and serial core
package uhb_pkg;
    typedef enum logic {UHB_MODE_DIR = 1'b0, UHB_MODE_STROBE = 1'b1} uhb_bus_mode_t;
    typedef enum logic {UHB_TX_IDLE = 1'b0, UHB_TX_SEND = 1'b1} uhb_tx_state_t;
endpackage

// ### hdl/uhb_fifo_if.sv
// byte fifo carrier between core and fifo
`timescale 1ns/1ps
`default_nettype none
interface uhb_fifo_if;
    logic       push;
    logic [7:0] wdata;
    logic       pop;
    logic       clear;
    logic [7:0] rdata;
    logic [6:0] count;
    logic       full;
    logic       empty;
    modport owner (input push, wdata, pop, clear, output rdata, count, full, empty);
    modport user  (output push, wdata, pop, clear, input rdata, count, full, empty);
endinterface
`default_nettype wire

// ### hdl/uhb_fifo.sv
// 64 byte fifo with head-of-queue read
`timescale 1ns/1ps
`default_nettype none
`include "uhb_defs.svh"
module uhb_fifo
    import uhb_pkg::*;
(
    // clock and reset
    input  wire logic   clock,
    input  wire logic   arst_n,
    // queue
    uhb_fifo_if.owner   f
);
    logic [7:0] mem [`UHB_FIFO_DEPTH];
    logic [5:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [6:0] cnt_r, cnt_nxt;
    logic       do_push, do_pop;

    assign do_push = f.push & ~f.full;
    assign do_pop  = f.pop & ~f.empty;
    assign f.rdata = mem[rp_r];
    assign f.count = cnt_r;
    assign f.full  = (cnt_r == 7'(`UHB_FIFO_DEPTH));
    assign f.empty = (cnt_r == 7'h00);

    always_comb begin
        wp_nxt  = wp_r + 6'(do_push);
        rp_nxt  = rp_r + 6'(do_pop);
        cnt_nxt = cnt_r + 7'(do_push) - 7'(do_pop);
        if (f.clear) begin
            wp_nxt  = 6'h00;
            rp_nxt  = 6'h00;
            cnt_nxt = 7'h00;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wp_r  <= 6'h00;
            rp_r  <= 6'h00;
            cnt_r <= 7'h00;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (do_push && !f.clear) begin
            mem[wp_r] <= f.wdata;
        end
    end
endmodule // uhb_fifo
`default_nettype wire

// ### hdl/uhb_host_port.sv
// host bus port, reset filter, straps and serial core
// How it works
// - eight data bits, three address lines, strobes
// - bus cycles need no baud clock running
// - direction mode ignores the read strobe
// - bus style pin picks the protocol
// - high selects strobes, low selects direction
// - filtered reset pulse clears registers and line, keeps the duplex bit
// - reset polarity follows the bus style
// - 64 byte fifos, triggers, xon/xoff flow
// - fractional divisor after divide by 1/4
// - duplex pin latched once after power-up
// - high pin half duplex, control bit overrides
// - power save isolates bus during sleep
`timescale 1ns/1ps
`default_nettype none
`include "uhb_defs.svh"
module uhb_host_port
    import uhb_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       arst_n,
    // host bus
    input  wire logic       bus_style_sel,
    input  wire logic       reset_pin,
    input  wire logic       cs_n,
    input  wire logic       read_strobe_n,
    input  wire logic       write_strobe_n,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    // power and straps
    input  wire logic       sleep_mode,
    input  wire logic       bus_isolate_req,
    input  wire logic       duplex_sel_pin,
    output logic            half_duplex,
    // serial side
    input  wire logic [7:0] rx_byte,
    input  wire logic       rx_byte_valid,
    output logic            tx_serial,
    output logic            tx_stopped,
    output logic            rx_trig_hit,
    output logic            tx_trig_hit
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    uhb_bus_mode_t mode;
    uhb_tx_state_t st_r, st_nxt;
    logic [2:0]  rst_cnt_r, rst_cnt_nxt;
    logic        rst_act, core_clr, iso_on, rd_lvl, wr_lvl, rd_go, wr_go;
    logic        prev_rd_r, prev_wr_r, oe_r, oe_nxt, strap_done_r, duplex_r, duplex_nxt;
    logic [7:0]  dout_r, dout_nxt, divl_r, divl_nxt, divh_r, divh_nxt;
    logic [7:0]  trig_r, trig_nxt, feature_ctrl_reg_r, feature_ctrl_reg_nxt, xoff_r, xoff_nxt, xon_r, xon_nxt;
    logic [3:0]  frac_r, frac_nxt, tick_cnt_r, tick_cnt_nxt, bit_cnt_r, bit_cnt_nxt;
    logic        presc_r, presc_nxt, stop_r, stop_nxt, ovr_r, ovr_nxt, line_r, line_nxt;
    logic [1:0]  pre_cnt_r;
    logic [20:0] acc_r, acc_nxt, acc_sum;
    logic [19:0] div_full;
    logic [9:0]  sh_r, sh_nxt;
    logic        pre_en, tick, flow_ctl, rx_stored;
    uhb_fifo_if  txf ();
    uhb_fifo_if  rxf ();

    uhb_fifo u_tx (.clock(clock), .arst_n(arst_n), .f(txf.owner));
    uhb_fifo u_rx (.clock(clock), .arst_n(arst_n), .f(rxf.owner));

    // ------------------------------------------------------------
    // reset filter and bus decode
    // ------------------------------------------------------------
    assign mode     = uhb_bus_mode_t'(bus_style_sel);
    assign rst_act  = (mode == UHB_MODE_STROBE) ? reset_pin : ~reset_pin;
    assign core_clr = rst_act && (rst_cnt_r == 3'(`UHB_RST_CYC));
    assign iso_on   = sleep_mode & bus_isolate_req;
    always_comb begin
        rst_cnt_nxt = 3'h0;
        if (rst_act) begin
            rst_cnt_nxt = core_clr ? rst_cnt_r : rst_cnt_r + 3'h1;
        end
        if (mode == UHB_MODE_STROBE) begin
            rd_lvl = ~cs_n & ~read_strobe_n;
            wr_lvl = ~cs_n & ~write_strobe_n;
        end else begin
            rd_lvl = ~cs_n & write_strobe_n;
            wr_lvl = ~cs_n & ~write_strobe_n;
        end
        rd_lvl = rd_lvl & ~iso_on & ~core_clr;
        wr_lvl = wr_lvl & ~iso_on & ~core_clr;
    end
    assign rd_go = rd_lvl & ~prev_rd_r;
    assign wr_go = wr_lvl & ~prev_wr_r;

    // ------------------------------------------------------------
    // baud tick: prescaler and fractional accumulator
    // ------------------------------------------------------------
    assign pre_en   = presc_r ? (pre_cnt_r == 2'h3) : 1'b1;
    assign div_full = ({divh_r, divl_r, frac_r} == 20'h0) ? `UHB_ONE_DIV : {divh_r, divl_r, frac_r};
    assign acc_sum  = acc_r + 21'(`UHB_ONE_DIV);
    assign tick     = pre_en && (acc_sum >= {1'b0, div_full});
    assign flow_ctl = feature_ctrl_reg_r[`UHB_FEATURE_CTRL_REG_FLOW];
    assign rx_stored = rx_byte_valid && !(flow_ctl && (rx_byte == xoff_r || rx_byte == xon_r));

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        {dout_nxt, oe_nxt, divl_nxt, divh_nxt, frac_nxt} = {dout_r, rd_lvl, divl_r, divh_r, frac_r};
        {presc_nxt, trig_nxt, feature_ctrl_reg_nxt, xoff_nxt, xon_nxt} = {presc_r, trig_r, feature_ctrl_reg_r, xoff_r, xon_r};
        {duplex_nxt, stop_nxt, sh_nxt} = {duplex_r, stop_r, sh_r};
        st_nxt = st_r;
        {tick_cnt_nxt, bit_cnt_nxt} = {tick_cnt_r, bit_cnt_r};
        acc_nxt   = pre_en ? (tick ? acc_sum - {1'b0, div_full} : acc_sum) : acc_r;
        ovr_nxt   = ovr_r;
        txf.push  = 1'b0;
        txf.pop   = 1'b0;
        txf.wdata = data_in;
        rxf.pop   = 1'b0;
        rxf.push  = rx_stored;
        rxf.wdata = rx_byte;
        if (!strap_done_r) begin
            duplex_nxt = duplex_sel_pin;
        end
        if (rd_go) begin
            if (addr == `UHB_A_DATA) begin
                dout_nxt = rxf.rdata;
                rxf.pop  = 1'b1;
            end else if (addr == `UHB_A_DIVL) begin
                dout_nxt = divl_r;
            end else if (addr == `UHB_A_DIVH) begin
                dout_nxt = divh_r;
            end else if (addr == `UHB_A_FRAC) begin
                dout_nxt = {presc_r, 3'h0, frac_r};
            end else if (addr == `UHB_A_TRIG) begin
                dout_nxt = trig_r;
            end else if (addr == `UHB_A_FEATURE_CTRL_REG) begin
                dout_nxt = feature_ctrl_reg_r;
                dout_nxt[`UHB_FEATURE_CTRL_REG_DUPLEX] = duplex_r;
            end else if (addr == `UHB_A_STAT) begin
                dout_nxt = {stop_r, ovr_r, txf.full, txf.empty, rxf.full, rxf.empty, st_r, 1'b0};
                ovr_nxt  = 1'b0;
            end else begin
                dout_nxt = {1'b0, rxf.count};
            end
        end
        if (rx_stored && rxf.full) begin
            ovr_nxt = 1'b1;                                                 // set wins over read clear
        end
        if (wr_go) begin
            if (addr == `UHB_A_DATA) begin
                txf.push = 1'b1;
            end else if (addr == `UHB_A_DIVL) begin
                divl_nxt = data_in;
            end else if (addr == `UHB_A_DIVH) begin
                divh_nxt = data_in;
            end else if (addr == `UHB_A_FRAC) begin
                frac_nxt  = data_in[3:0];
                presc_nxt = data_in[`UHB_FRAC_PRESC];
            end else if (addr == `UHB_A_TRIG) begin
                trig_nxt = data_in;
            end else if (addr == `UHB_A_FEATURE_CTRL_REG) begin
                feature_ctrl_reg_nxt   = data_in;
                duplex_nxt = data_in[`UHB_FEATURE_CTRL_REG_DUPLEX];
            end else if (addr == `UHB_A_STAT) begin
                xoff_nxt = data_in;
            end else begin
                xon_nxt = data_in;
            end
        end
        if (flow_ctl && rx_byte_valid && rx_byte == xoff_r) begin
            stop_nxt = 1'b1;
        end else if (flow_ctl && rx_byte_valid && rx_byte == xon_r) begin
            stop_nxt = 1'b0;
        end else if (!flow_ctl) begin
            stop_nxt = 1'b0;
        end
        case (st_r)
            UHB_TX_IDLE: begin
                if (tick && !txf.empty && !stop_r) begin
                    sh_nxt       = {1'b1, txf.rdata, 1'b0};
                    txf.pop      = 1'b1;
                    tick_cnt_nxt = 4'h0;
                    bit_cnt_nxt  = 4'h0;
                    st_nxt       = UHB_TX_SEND;
                end
            end
            default: begin
                if (tick) begin
                    tick_cnt_nxt = tick_cnt_r + 4'h1;
                    if (tick_cnt_r == 4'hf) begin
                        sh_nxt      = {1'b1, sh_r[9:1]};
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                        if (bit_cnt_r == 4'h9) begin
                            st_nxt = UHB_TX_IDLE;
                        end
                    end
                end
            end
        endcase
        line_nxt  = (st_nxt == UHB_TX_SEND) ? sh_nxt[0] : 1'b1;
        txf.clear = core_clr;
        rxf.clear = core_clr;
        if (core_clr) begin
            {divl_nxt, divh_nxt, frac_nxt, presc_nxt} = {`UHB_DIVL_RST, `UHB_DIVH_RST, `UHB_FRAC_RST, 1'b0};
            {trig_nxt, feature_ctrl_reg_nxt, xoff_nxt, xon_nxt} = {`UHB_TRIG_RST, `UHB_FEATURE_CTRL_REG_RST, `UHB_XOFF_RST, `UHB_XON_RST};
            {stop_nxt, ovr_nxt, line_nxt, acc_nxt} = {1'b0, 1'b0, 1'b1, 21'h0};
            st_nxt = UHB_TX_IDLE;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            {rst_cnt_r, prev_rd_r, prev_wr_r, oe_r, dout_r} <= {3'h0, 1'b0, 1'b0, 1'b0, 8'h00};
            {strap_done_r, duplex_r, stop_r, ovr_r, line_r} <= {1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
            {divl_r, divh_r, frac_r, presc_r} <= {`UHB_DIVL_RST, `UHB_DIVH_RST, `UHB_FRAC_RST, 1'b0};
            {trig_r, feature_ctrl_reg_r, xoff_r, xon_r} <= {`UHB_TRIG_RST, `UHB_FEATURE_CTRL_REG_RST, `UHB_XOFF_RST, `UHB_XON_RST};
            st_r <= UHB_TX_IDLE;
            {sh_r, tick_cnt_r, bit_cnt_r} <= {10'h3ff, 4'h0, 4'h0};
            {pre_cnt_r, acc_r} <= {2'h0, 21'h0};
        end else begin
            {rst_cnt_r, prev_rd_r, prev_wr_r, oe_r, dout_r} <= {rst_cnt_nxt, rd_lvl, wr_lvl, oe_nxt, dout_nxt};
            {strap_done_r, duplex_r, stop_r, ovr_r, line_r} <= {1'b1, duplex_nxt, stop_nxt, ovr_nxt, line_nxt};
            {divl_r, divh_r, frac_r, presc_r} <= {divl_nxt, divh_nxt, frac_nxt, presc_nxt};
            {trig_r, feature_ctrl_reg_r, xoff_r, xon_r} <= {trig_nxt, feature_ctrl_reg_nxt, xoff_nxt, xon_nxt};
            st_r <= st_nxt;
            {sh_r, tick_cnt_r, bit_cnt_r} <= {sh_nxt, tick_cnt_nxt, bit_cnt_nxt};
            {pre_cnt_r, acc_r} <= {pre_cnt_r + 2'h1, acc_nxt};
        end
    end

    assign data_out    = dout_r;
    assign data_oe     = oe_r;
    assign half_duplex = duplex_r;
    assign tx_serial   = line_r;
    assign tx_stopped  = stop_r;
    assign rx_trig_hit = rxf.count > {1'b0, trig_r[3:0], 2'b00};
    assign tx_trig_hit = txf.count <= {1'b0, trig_r[7:4], 2'b00};

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    property p_rst_long;
        rst_act [*5] |-> core_clr;
    endproperty
    a_rst_long: assert property (p_rst_long) else $error("long reset pulse not taken");

    property p_rst_short;
        $rose(rst_act) |-> !core_clr [*4];
    endproperty
    a_rst_short: assert property (p_rst_short) else $error("short reset pulse taken");

    property p_rst_clear;
        core_clr |=> divl_r == `UHB_DIVL_RST && tx_serial && !tx_stopped;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("reset left state behind");

    property p_dir_no_read;
        !bus_style_sel && !cs_n && !write_strobe_n |=> !data_oe;
    endproperty
    a_dir_no_read: assert property (p_dir_no_read) else $error("read strobe honoured in direction mode");

    property p_strobe_read;
        bus_style_sel && !cs_n && !read_strobe_n && !iso_on && !core_clr |=> data_oe;
    endproperty
    a_strobe_read: assert property (p_strobe_read) else $error("strobe read not driven");

    property p_dir_read;
        !bus_style_sel && !cs_n && write_strobe_n && !iso_on && !core_clr |=> data_oe;
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("direction read not driven");

    property p_isolate;
        iso_on |=> !data_oe && $stable(divl_r);
    endproperty
    a_isolate: assert property (p_isolate) else $error("bus not isolated");

    property p_strap;
        $rose(strap_done_r) |-> half_duplex == $past(duplex_sel_pin);
    endproperty
    a_strap: assert property (p_strap) else $error("duplex strap not latched");

    property p_feature_ctrl_reg;
        wr_go && addr == `UHB_A_FEATURE_CTRL_REG |=> half_duplex == $past(data_in[3]);
    endproperty
    a_feature_ctrl_reg: assert property (p_feature_ctrl_reg) else $error("duplex override lost");

    property p_xoff;
        flow_ctl && rx_byte_valid && rx_byte == xoff_r && !core_clr |=> tx_stopped ##1 (!$rose(st_r == UHB_TX_SEND)) [*2];
    endproperty
    a_xoff: assert property (p_xoff) else $error("xoff did not stop sender");

    c_strobe_write: cover property (bus_style_sel && wr_go);
    c_dir_read: cover property (!bus_style_sel && rd_go);
    c_tx_frame: cover property (st_r == UHB_TX_SEND ##1 st_r == UHB_TX_IDLE);
    c_reset: cover property (core_clr);
endmodule // uhb_host_port
`default_nettype wire

// ### test/uhb_host_model.sv
// host processor model driving the strobe or direction bus
`timescale 1ns/1ps
`default_nettype none
module uhb_host_model (
    // clock
    input  wire logic       clock,
    // bus pins
    output logic            bus_style_sel,
    output logic            reset_pin,
    // factory test pins, strapped low by the board
    output logic            factory_test_in_a,
    output logic            factory_test_in_b,
    output logic            factory_test_in_c,
    output logic            cs_n,
    output logic            read_strobe_n,
    output logic            write_strobe_n,
    output logic      [2:0] addr,
    output logic      [7:0] data_in,
    // answer
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe
);
    initial begin
        bus_style_sel = 1'b1;
        reset_pin = 1'b0;
        factory_test_in_a = 1'b0;
        factory_test_in_b = 1'b0;
        factory_test_in_c = 1'b0;
        cs_n = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        addr = 3'h0;
        data_in = 8'h00;
    end

    // unconnected read pin in direction mode floats, modelled as toggling
    always @(posedge clock) begin
        if (bus_style_sel === 1'b0) read_strobe_n <= ~read_strobe_n;
    end

    task automatic set_mode(input logic m);
        @(posedge clock);
        bus_style_sel <= m;
        reset_pin <= ~m;
        repeat (2) @(posedge clock);
        // the floating read pin must not be left low once strobes are back
        if (m) read_strobe_n <= 1'b1;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        cs_n <= 1'b0;
        addr <= a;
        data_in <= d;
        write_strobe_n <= 1'b0;
        repeat (2) @(posedge clock);
        cs_n <= 1'b1;
        write_strobe_n <= 1'b1;
        data_in <= ~d;
        @(posedge clock);
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic got);
        int n;
        got = 1'b0;
        d = 8'h00;
        @(posedge clock);
        cs_n <= 1'b0;
        addr <= a;
        if (bus_style_sel) read_strobe_n <= 1'b0;
        else write_strobe_n <= 1'b1;
        for (n = 0; n < 6 && !got; n++) begin
            @(posedge clock);
            if (data_oe === 1'b1) begin
                got = 1'b1;
                d = data_out;
            end
        end
        cs_n <= 1'b1;
        if (bus_style_sel) read_strobe_n <= 1'b1;
        @(posedge clock);
    endtask

    task automatic rst_pulse(input int n);
        @(posedge clock);
        reset_pin <= bus_style_sel;
        repeat (n) @(posedge clock);
        reset_pin <= ~bus_style_sel;
        repeat (2) @(posedge clock);
    endtask
endmodule // uhb_host_model
`default_nettype wire

// ### test/testbench.sv
// self-checking bench of the host port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {logic [2:0] a; logic w; logic [7:0] d; logic [7:0] e;} uhb_row_t;
    logic       clock, arst_n, sleep_mode, bus_isolate_req, duplex_sel_pin, rx_byte_valid;
    logic       bus_style_sel, reset_pin, cs_n, read_strobe_n, write_strobe_n, data_oe;
    logic       half_duplex, tx_serial, tx_stopped, rx_trig_hit, tx_trig_hit, got;
    logic       factory_test_in_a, factory_test_in_b, factory_test_in_c;
    logic [2:0] addr;
    logic [7:0] data_in, data_out, rx_byte, v;
    int         num_errors = 0, cmp_count = 0, bad_oe = 0, n;
    uhb_row_t   rows [15] = '{'{3'h1, 1'b0, 8'h00, 8'h01}, '{3'h2, 1'b0, 8'h00, 8'h00},
                              '{3'h3, 1'b0, 8'h00, 8'h00}, '{3'h4, 1'b0, 8'h00, 8'h00},
                              '{3'h5, 1'b0, 8'h00, 8'h08}, '{3'h6, 1'b0, 8'h00, 8'h14},
                              '{3'h7, 1'b0, 8'h00, 8'h00}, '{3'h1, 1'b1, 8'ha5, 8'ha5},
                              '{3'h2, 1'b1, 8'h3c, 8'h3c}, '{3'h3, 1'b1, 8'h8f, 8'h8f},
                              '{3'h4, 1'b1, 8'h5a, 8'h5a}, '{3'h1, 1'b1, 8'h01, 8'h01},
                              '{3'h2, 1'b1, 8'h00, 8'h00}, '{3'h3, 1'b1, 8'h00, 8'h00},
                              '{3'h4, 1'b1, 8'h00, 8'h00}};

    uhb_host_port dut (.clock(clock), .arst_n(arst_n), .bus_style_sel(bus_style_sel), .reset_pin(reset_pin),
        .cs_n(cs_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .addr(addr),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .sleep_mode(sleep_mode),
        .bus_isolate_req(bus_isolate_req), .duplex_sel_pin(duplex_sel_pin), .half_duplex(half_duplex),
        .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid), .tx_serial(tx_serial), .tx_stopped(tx_stopped),
        .rx_trig_hit(rx_trig_hit), .tx_trig_hit(tx_trig_hit));

    uhb_host_model host (.clock(clock), .bus_style_sel(bus_style_sel), .reset_pin(reset_pin), .cs_n(cs_n),
        .factory_test_in_a(factory_test_in_a), .factory_test_in_b(factory_test_in_b),
        .factory_test_in_c(factory_test_in_c),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // device must never drive the data bus during a write cycle
    always @(posedge clock) begin
        if (cs_n === 1'b0 && write_strobe_n === 1'b0 && data_oe === 1'b1) bad_oe++;
    end

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic feed(input logic [7:0] b);
        @(posedge clock);
        rx_byte <= b;
        rx_byte_valid <= 1'b1;
        @(posedge clock);
        rx_byte_valid <= 1'b0;
        rx_byte <= ~b;
        repeat (2) @(posedge clock);
    endtask

    task automatic give_verdict();
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        $display("watchdog expired");
        give_verdict();
    end

    initial begin
        arst_n = 1'b0;
        sleep_mode = 1'b0;
        bus_isolate_req = 1'b0;
        duplex_sel_pin = 1'b1;
        rx_byte = 8'h00;
        rx_byte_valid = 1'b0;
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        repeat (2) @(posedge clock);
        check("half_duplex", {7'h00, half_duplex}, 8'h01);
        check("test_pins", {5'h00, factory_test_in_a, factory_test_in_b, factory_test_in_c}, 8'h00);
        foreach (rows[i]) begin
            if (rows[i].w) host.wr(rows[i].a, rows[i].d);
            host.rd(rows[i].a, v, got);
            check("row_read", v, rows[i].e);
        end
        host.wr(3'h1, 8'h5a);
        host.rst_pulse(4);
        host.rd(3'h1, v, got);
        check("short_reset", v, 8'h5a);
        host.rst_pulse(6);
        host.rd(3'h1, v, got);
        check("long_reset", v, 8'h01);
        check("duplex_kept", {7'h00, half_duplex}, 8'h01);
        host.set_mode(1'b0);
        host.wr(3'h2, 8'h77);
        host.rd(3'h2, v, got);
        check("dir_read", v, 8'h77);
        host.rst_pulse(6);
        host.rd(3'h2, v, got);
        check("dir_reset", v, 8'h00);
        check("oe_in_write", bad_oe[7:0], 8'h00);
        host.set_mode(1'b1);
        sleep_mode <= 1'b1;
        bus_isolate_req <= 1'b1;
        host.wr(3'h1, 8'hee);
        host.rd(3'h1, v, got);
        check("iso_answer", {7'h00, got}, 8'h00);
        sleep_mode <= 1'b0;
        host.rd(3'h1, v, got);
        check("iso_write_lost", v, 8'h01);
        bus_isolate_req <= 1'b0;
        host.wr(3'h5, 8'h00);
        check("duplex_override", {7'h00, half_duplex}, 8'h00);
        host.wr(3'h0, 8'h55);
        got = 1'b0;
        for (n = 0; n < 60 && !got; n++) begin
            @(posedge clock);
            got = (tx_serial === 1'b0);
        end
        check("tx_start_bit", {7'h00, got}, 8'h01);
        host.wr(3'h4, 8'h01);
        check("tx_trig", {7'h00, tx_trig_hit}, 8'h01);
        for (n = 0; n < 5; n++) begin
            check("rx_trig_low", {7'h00, rx_trig_hit}, 8'h00);
            feed(8'h30 + n[7:0]);
        end
        check("rx_trig_high", {7'h00, rx_trig_hit}, 8'h01);
        host.rd(3'h7, v, got);
        check("rx_count", v, 8'h05);
        host.rd(3'h0, v, got);
        check("rx_head", v, 8'h30);
        host.wr(3'h5, 8'h01);
        feed(8'h13);
        check("xoff_seen", {7'h00, tx_stopped}, 8'h01);
        feed(8'h11);
        check("xon_seen", {7'h00, tx_stopped}, 8'h00);
        host.rd(3'h7, v, got);
        check("flow_not_stored", v, 8'h04);
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
